// >>> hdl/dlim_pkg.sv
// Shared constants for the line link and loop monitor block
package dlim_pkg;
   localparam int CLOCK_PERIOD_NS = 8;
   localparam int CLOCK_HZ = 1000000000 / CLOCK_PERIOD_NS;
   localparam int ADDR_W = 8;
   localparam int IDX_W = 6;
   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_EVENTS = 6'h04;
   localparam logic [IDX_W-1:0] IDX_OFF_HOOK = 6'h05;
   localparam logic [IDX_W-1:0] IDX_POWER = 6'h06;
   localparam logic [IDX_W-1:0] IDX_RATE = 6'h07;
   localparam logic [IDX_W-1:0] IDX_STATUS = 6'h0c;
   localparam logic [IDX_W-1:0] IDX_RX_MON = 6'h14;
   localparam logic [IDX_W-1:0] IDX_TX_MON = 6'h15;
   localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR = 6'h20;
   localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 6'h21;
   localparam logic [IDX_W-1:0] IDX_FILTER_EDGES = 6'h22;
   // Field positions
   localparam int POWER_DOWN_BIT = 4;
   localparam int OFF_HOOK_BIT = 0;
   localparam int FRAME_DETECT_BIT = 6;
   localparam int EV_FRAME_BIT = 0;
   localparam int EV_RING_BIT = 1;
   localparam int EV_OVERLOAD_BIT = 2;
   localparam int EV_DROPOUT_BIT = 3;
   localparam int NUM_EVENTS = 4;
   // Values after reset
   localparam logic POWER_DOWN_RESET = 1'b1;
   localparam logic [3:0] RATE_RESET = 4'h0;
   // Sample rate codes and rates in Hz
   localparam logic [3:0] RATE_8000 = 4'h0;
   localparam logic [3:0] RATE_9600 = 4'h1;
   localparam logic [3:0] RATE_7200 = 4'h2;
   localparam logic [3:0] RATE_16000 = 4'h3;
   localparam int HZ_8000 = 8000;
   localparam int HZ_9600 = 9600;
   localparam int HZ_7200 = 7200;
   localparam int HZ_16000 = 16000;
   // Filter edges as fractions of the rate: 0.4125 and 0.45
   localparam int PB01_NUM = 33;
   localparam int PB01_DEN = 80;
   localparam int PB3_NUM = 9;
   localparam int PB3_DEN = 20;
   // Loop current step, tenths of mA per code
   localparam int LOOP_STEP_TENTH_MA = 33;
   localparam logic [4:0] LOOP_MAX = 5'h1f;
   // Link framing
   localparam logic [2:0] LOCK_FRAMES = 3'h4;
   localparam logic [1:0] MISS_LIMIT = 2'h2;
   localparam int LINK_TX_W = 40;
   localparam int LINK_RX_W = 32;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : dlim_pkg

// >>> hdl/dlim_sync_if.sv
// Raw and filtered pin bundle between the top and its synchroniser
`timescale 1ns/1ps
interface dlim_sync_if #(parameter int W = 1) (
   input wire logic clock,
   input wire logic arst_n
);
   logic [W-1:0] raw;
   logic [W-1:0] clean;
   modport sync (input clock, input arst_n, input raw, output clean);
   modport user (output raw, input clean);
endinterface : dlim_sync_if

// >>> hdl/dlim_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module dlim_sync (
   dlim_sync_if.sync sif
);
   localparam int W = $bits(sif.raw);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] clean;
   } dlim_sync_state_t;
   dlim_sync_state_t s;
   dlim_sync_state_t next_s;

   always_comb begin
      next_s = s;
      next_s.s1 = sif.raw;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      // A bit moves only once stages two and three agree
      next_s.clean = (s.s3 & ~(s.s2 ^ s.s3)) | (s.clean & (s.s2 ^ s.s3));
   end

   always_ff @(posedge sif.clock or negedge sif.arst_n) begin
      if (!sif.arst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign sif.clean = s.clean;
endmodule : dlim_sync

// >>> hdl/dlim_top.sv
// System-side link control, loop monitor and register slave
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
module dlim_top
   import dlim_pkg::*;
#(
   parameter int CLK_HZ = CLOCK_HZ
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic irq,
   output logic link_tx_enable,
   output logic link_tx_frame,
   output logic [LINK_TX_W-1:0] link_tx_word,
   input wire logic link_rx_toggle,
   input wire logic [LINK_RX_W-1:0] link_rx_word,
   input wire logic [15:0] tx_sample_data,
   input wire logic tx_sample_valid,
   output logic tx_sample_ready,
   output logic [15:0] rx_sample_data,
   output logic rx_sample_valid,
   output logic ring_detect,
   output logic [7:0] cid_data,
   output logic cid_valid
);
   if (CLK_HZ < 3 * HZ_16000) begin : g_clk_check
      $error("CLK_HZ too low for the fastest sample rate");
   end

   typedef struct packed {
      logic aw_held;
      logic [IDX_W-1:0] aw_idx;
      logic w_held;
      logic [31:0] w_data;
      logic w_lane0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic power_down;
      logic off_hook;
      logic [3:0] rate;
      logic [7:0] rx_mon;
      logic [7:0] tx_mon;
      logic [NUM_EVENTS-1:0] irq_en;
      logic [NUM_EVENTS-1:0] flags;
      logic [19:0] tick_cnt;
      logic tx_frame;
      logic [LINK_TX_W-1:0] tx_word;
      logic rx_toggle_seen;
      logic [2:0] lock_cnt;
      logic [1:0] miss_cnt;
      logic frame_detect;
      logic [4:0] loop_level;
      logic ring;
      logic [15:0] rx_sample;
      logic rx_valid;
      logic [7:0] cid;
      logic cid_valid;
   } dlim_state_t;

   dlim_state_t s;
   dlim_state_t next_s;
   logic tick;
   logic rx_edge;
   logic [NUM_EVENTS-1:0] clr;
   logic [NUM_EVENTS-1:0] ev;
   logic [LINK_RX_W:0] rx_clean;

   dlim_sync_if #(.W(LINK_RX_W + 1)) rx_if (.clock(clock), .arst_n(arst_n));
   assign rx_if.raw = {link_rx_toggle, link_rx_word};
   assign rx_clean = rx_if.clean;
   dlim_sync i_dlim_sync (.sif(rx_if));

   function automatic int rate_hz(input logic [3:0] code);
      unique case (code)
         RATE_9600: return HZ_9600;
         RATE_7200: return HZ_7200;
         RATE_16000: return HZ_16000;
         default: return HZ_8000;
      endcase
   endfunction : rate_hz

   function automatic logic mapped(input logic [IDX_W-1:0] idx);
      return idx inside {IDX_EVENTS, IDX_OFF_HOOK, IDX_POWER, IDX_RATE,
         IDX_STATUS, IDX_RX_MON, IDX_TX_MON, IDX_IRQ_CLEAR, IDX_IRQ_ENABLE,
         IDX_FILTER_EDGES};
   endfunction : mapped

   function automatic logic [31:0] read_reg(input dlim_state_t st,
                                            input logic [IDX_W-1:0] idx);
      logic [31:0] v;
      int hz;
      v = '0;
      hz = rate_hz(st.rate);
      unique case (idx)
         IDX_EVENTS: v[NUM_EVENTS-1:0] = st.flags;
         IDX_OFF_HOOK: v[OFF_HOOK_BIT] = st.off_hook;
         IDX_POWER: v[POWER_DOWN_BIT] = st.power_down;
         IDX_RATE: v[3:0] = st.rate;
         IDX_STATUS: begin
            v[FRAME_DETECT_BIT] = st.frame_detect;
            v[4:0] = st.loop_level;
         end
         IDX_RX_MON: v[7:0] = st.rx_mon;
         IDX_TX_MON: v[7:0] = st.tx_mon;
         IDX_IRQ_ENABLE: v[NUM_EVENTS-1:0] = st.irq_en;
         IDX_FILTER_EDGES: begin
            v[15:0] = 16'((hz * PB01_NUM) / PB01_DEN);
            v[31:16] = 16'((hz * PB3_NUM) / PB3_DEN);
         end
         default: v = '0;
      endcase
      return v;
   endfunction : read_reg

   assign tick = (s.tick_cnt == '0);
   assign rx_edge = (rx_clean[LINK_RX_W] != s.rx_toggle_seen);
   assign s_axi_awready = !s.aw_held && !s.bvalid;
   assign s_axi_wready = !s.w_held && !s.bvalid;
   assign s_axi_arready = !s.rvalid;
   assign tx_sample_ready = tick && s.frame_detect && !s.power_down;

   always_comb begin
      next_s = s;
      clr = '0;
      next_s.tx_frame = 1'b0;
      next_s.rx_valid = 1'b0;
      next_s.cid_valid = 1'b0;
      // Register slave, address and data in either order
      if (s_axi_awvalid && s_axi_awready) begin
         next_s.aw_held = 1'b1;
         next_s.aw_idx = s_axi_awaddr[ADDR_W-1:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_s.w_held = 1'b1;
         next_s.w_data = s_axi_wdata;
         next_s.w_lane0 = s_axi_wstrb[0];
      end
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end
      if (s.aw_held && s.w_held && !s.bvalid) begin
         next_s.aw_held = 1'b0;
         next_s.w_held = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = mapped(s.aw_idx) ? RESP_OKAY : RESP_SLVERR;
         if (s.w_lane0) begin
            unique case (s.aw_idx)
               IDX_OFF_HOOK: next_s.off_hook = s.w_data[OFF_HOOK_BIT];
               IDX_POWER: next_s.power_down = s.w_data[POWER_DOWN_BIT];
               IDX_RATE: next_s.rate = s.w_data[3:0];
               IDX_RX_MON: next_s.rx_mon = s.w_data[7:0];
               IDX_TX_MON: next_s.tx_mon = s.w_data[7:0];
               IDX_IRQ_CLEAR: clr = s.w_data[NUM_EVENTS-1:0];
               IDX_IRQ_ENABLE: next_s.irq_en = s.w_data[NUM_EVENTS-1:0];
               default: ;
            endcase
         end
      end
      if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_s.rvalid = 1'b1;
         next_s.rdata = read_reg(s, s_axi_araddr[ADDR_W-1:2]);
         next_s.rresp = mapped(s_axi_araddr[ADDR_W-1:2]) ? RESP_OKAY
                                                         : RESP_SLVERR;
      end
      // Sample-rate timebase
      next_s.tick_cnt = tick ? 20'(CLK_HZ / rate_hz(s.rate) - 1)
                             : s.tick_cnt - 20'h1;
      // Outbound frame, payload withheld until framed
      // No frame launched in the cycle that powers the link down
      if (tick && !s.power_down && !next_s.power_down) begin
         next_s.tx_frame = 1'b1;
         next_s.tx_word = '0;
         if (s.frame_detect) begin
            next_s.tx_word = {3'h0, s.off_hook, s.rate, s.tx_mon, s.rx_mon,
               tx_sample_valid ? tx_sample_data : 16'h0};
         end
      end
      // Inbound framing
      next_s.rx_toggle_seen = rx_clean[LINK_RX_W];
      if (next_s.power_down) begin
         next_s.lock_cnt = '0;
         next_s.miss_cnt = '0;
         next_s.frame_detect = 1'b0;
         next_s.ring = 1'b0;
      end else if (rx_edge) begin
         next_s.miss_cnt = '0;
         if (s.lock_cnt != LOCK_FRAMES) begin
            next_s.lock_cnt = s.lock_cnt + 3'h1;
         end else begin
            next_s.frame_detect = 1'b1;
         end
         if (s.frame_detect) begin
            next_s.rx_sample = rx_clean[15:0];
            next_s.rx_valid = 1'b1;
            next_s.loop_level = rx_clean[20:16];
            next_s.ring = rx_clean[21];
            next_s.cid = rx_clean[31:24];
            next_s.cid_valid = rx_clean[23];
         end
      end else if (tick) begin
         if (s.miss_cnt == MISS_LIMIT - 2'h1) begin
            next_s.miss_cnt = '0;
            next_s.lock_cnt = '0;
            next_s.frame_detect = 1'b0;
         end else begin
            next_s.miss_cnt = s.miss_cnt + 2'h1;
         end
      end
      if (!next_s.off_hook) begin
         next_s.loop_level = '0;
      end
      // Sticky events, a new event beats its clear
      ev = '0;
      ev[EV_FRAME_BIT] = next_s.frame_detect && !s.frame_detect;
      ev[EV_RING_BIT] = next_s.ring && !s.ring;
      ev[EV_OVERLOAD_BIT] = (next_s.loop_level == LOOP_MAX)
         && (s.loop_level != LOOP_MAX);
      ev[EV_DROPOUT_BIT] = s.frame_detect && rx_edge && rx_clean[22];
      next_s.flags = (s.flags & ~clr) | ev;
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s <= '0;
         s.power_down <= POWER_DOWN_RESET;
         s.rate <= RATE_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign s_axi_bresp = s.bresp;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   assign s_axi_rvalid = s.rvalid;
   assign irq = |(s.flags & s.irq_en);
   assign link_tx_enable = !s.power_down;
   assign link_tx_frame = s.tx_frame;
   assign link_tx_word = s.tx_word;
   assign rx_sample_data = s.rx_sample;
   assign rx_sample_valid = s.rx_valid;
   assign ring_detect = s.ring;
   assign cid_data = s.cid;
   assign cid_valid = s.cid_valid;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);

   sequence overload_reached;
      s.loop_level == LOOP_MAX && $past(s.loop_level) != LOOP_MAX;
   endsequence
   sequence frame_rise;
      $rose(s.frame_detect);
   endsequence

   AST_LINK_OFF_WHEN_DOWN: assert property (
      s.power_down |-> !link_tx_enable && !link_tx_frame)
      else $error("link active while powered down");
   AST_FRAME_LOW_WHEN_DOWN: assert property (
      s.power_down |-> !s.frame_detect)
      else $error("frame detect set while powered down");
   AST_FRAME_AFTER_LOCK: assert property (
      frame_rise |-> $past(s.lock_cnt) == LOCK_FRAMES)
      else $error("frame detect set before lock count");
   AST_NO_TX_UNFRAMED: assert property (
      link_tx_frame && !$past(s.frame_detect) |-> link_tx_word == '0)
      else $error("payload sent before framing");
   AST_RX_GATED: assert property (
      rx_sample_valid |-> $past(s.frame_detect) && !$past(s.power_down))
      else $error("sample received before framing");
   AST_LOOP_ONLY_OFF_HOOK: assert property (
      !s.off_hook |-> s.loop_level == 5'h00)
      else $error("loop current shown while on hook");
   AST_OVERLOAD_FLAG: assert property (
      overload_reached |-> s.flags[EV_OVERLOAD_BIT])
      else $error("overload flag not raised at full scale");
   AST_HOOK_CARRIED: assert property (
      link_tx_frame && $past(s.frame_detect) |->
         link_tx_word[36] == $past(s.off_hook))
      else $error("off-hook state not carried on link");
endmodule : dlim_top

// >>> sim/dlim_line_model.sv
// Line-side partner: answers every system frame with one reply frame
`timescale 1ns/1ps
module dlim_line_model (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic link_tx_frame,
   input wire logic [4:0] loop_code,
   input wire logic ring,
   input wire logic dropout,
   output logic link_rx_toggle,
   output logic [31:0] link_rx_word
);
   logic [3:0] delay;
   logic [15:0] count;
   // Word settles six clocks before the toggle, holds until next frame
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         delay <= 4'h0;
         count <= 16'h0000;
         link_rx_toggle <= 1'b0;
         link_rx_word <= 32'h00000000;
      end else if (link_tx_frame) begin
         delay <= 4'h6;
         count <= count + 16'h0001;
         link_rx_word <= {count[7:0], 1'b1, dropout, ring, loop_code,
            count};
      end else if (delay != 4'h0) begin
         delay <= delay - 4'h1;
         if (delay == 4'h1) begin
            link_rx_toggle <= ~link_rx_toggle;
         end
      end
   end
endmodule : dlim_line_model

// >>> sim/daa_link_init_loop_monitor_bench.sv
// Register-level bench of the line link and loop monitor block
`timescale 1ns/1ps
module daa_link_init_loop_monitor_bench;
   import dlim_pkg::*;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, irq, link_tx_enable, link_tx_frame, link_rx_toggle;
   logic [LINK_TX_W-1:0] link_tx_word;
   logic [LINK_RX_W-1:0] link_rx_word;
   logic [15:0] tx_sample_data = 16'h0, rx_sample_data;
   logic tx_sample_valid = 1'b0, tx_sample_ready, rx_sample_valid;
   logic ring_detect, cid_valid, ring = 1'b0, dropout = 1'b0;
   logic [7:0] cid_data;
   logic [4:0] loop_code = 5'h00;
   logic [31:0] rd;
   logic [1:0] rsp;
   int miscompares = 0, total_checks = 0, frames = 0, rxn = 0, cidn = 0;
   int txr = 0;
   logic [15:0] last_rx = 16'h0;
   int hz [4] = '{HZ_8000, HZ_9600, HZ_7200, HZ_16000};

   dlim_top #(.CLK_HZ(480000)) i_dlim_top (.clock, .arst_n, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq,
      .link_tx_enable, .link_tx_frame, .link_tx_word, .link_rx_toggle,
      .link_rx_word, .tx_sample_data, .tx_sample_valid, .tx_sample_ready,
      .rx_sample_data, .rx_sample_valid, .ring_detect, .cid_data,
      .cid_valid);
   dlim_line_model i_dlim_line_model (.clock, .arst_n, .link_tx_frame,
      .loop_code, .ring, .dropout, .link_rx_toggle, .link_rx_word);

   always #4 clock = ~clock;
   always @(posedge clock) begin
      // Line model numbers its frames; samples must arrive in sequence
      if (rx_sample_valid === 1'b1 && rxn > 0) begin
         chk("rx sample", 16'(last_rx + 16'h1), rx_sample_data);
      end
      if (cid_valid === 1'b1) begin
         chk("cid byte", rx_sample_data[7:0], cid_data);
      end
      if (rx_sample_valid === 1'b1) begin
         last_rx = rx_sample_data;
      end
      txr += (tx_sample_ready === 1'b1);
      frames += (link_tx_frame === 1'b1);
      rxn += (rx_sample_valid === 1'b1);
      cidn += (cid_valid === 1'b1);
   end

   task automatic report_and_stop;
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : report_and_stop

   task automatic hang(input string nm);
      miscompares++;
      $display("MISMATCH %s expected answer seen none", nm);
      report_and_stop();
   endtask : hang

   task automatic chk(input string nm, input logic [39:0] e,
         input logic [39:0] g);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wr(input logic [IDX_W-1:0] i, input logic [31:0] d,
         input logic [1:0] er = RESP_OKAY);
      int n;
      s_axi_awaddr <= {i, 2'b00};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clock);
         if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      if (n == 100) hang("bvalid");
      chk("bresp", er, s_axi_bresp);
      s_axi_bready <= 1'b0;
      @(posedge clock);
   endtask : wr

   task automatic rdc(input string nm, input logic [IDX_W-1:0] i,
         input logic [31:0] m, input logic [31:0] e,
         input logic [1:0] er = RESP_OKAY);
      int n;
      s_axi_araddr <= {i, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clock);
         if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      if (n == 100) hang("rvalid");
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clock);
      if (nm != "") chk(nm, e, rd & m);
      chk("rresp", er, rsp);
   endtask : rdc

   task automatic wait_frame;
      int n;
      for (n = 0; n < 200; n++) begin
         @(posedge clock);
         if (link_tx_frame === 1'b1) break;
      end
      if (n == 200) hang("frame");
   endtask : wait_frame

   initial begin
      int k;
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      chk("tx_enable", 0, link_tx_enable);
      rdc("power", IDX_POWER, 32'hffffffff, 32'h10);
      rdc("status", IDX_STATUS, 32'hffffffff, 0);
      rdc("unmapped", 6'h3f, 32'hffffffff, 0, RESP_SLVERR);
      wr(6'h3f, 32'hff, RESP_SLVERR);
      for (k = 0; k < 4; k++) begin
         wr(IDX_RATE, k);
         rdc("rate", IDX_RATE, 32'hf, k);
         rdc("edges", IDX_FILTER_EDGES, 32'hffffffff, {16'(hz[k] * PB3_NUM
            / PB3_DEN), 16'(hz[k] * PB01_NUM / PB01_DEN)});
      end
      repeat (100) @(posedge clock);
      chk("frames down", 0, frames);
      chk("ready down", 0, txr);
      wr(IDX_RX_MON, 32'h5a);
      wr(IDX_TX_MON, 32'ha5);
      rdc("tx_mon", IDX_TX_MON, 32'hff, 32'ha5);
      s_axi_wstrb <= 4'he;
      wr(IDX_RX_MON, 32'h11);
      s_axi_wstrb <= 4'hf;
      rdc("rx_mon lane0 off", IDX_RX_MON, 32'hff, 32'h5a);
      wr(IDX_IRQ_ENABLE, 32'hf);
      chk("irq idle", 0, irq);
      tx_sample_data <= 16'h1234;
      tx_sample_valid <= 1'b1;
      wr(IDX_POWER, 0);
      chk("tx_enable", 1, link_tx_enable);
      for (k = 0; k < 100; k++) begin
         rdc("", IDX_STATUS, 0, 0);
         if (rd[FRAME_DETECT_BIT] === 1'b1) break;
      end
      if (k == 100) hang("frame detect");
      rdc("framed", IDX_EVENTS, 32'h1, 32'h1);
      chk("irq", 1, irq);
      wait_frame();
      chk("tx word", {8'h03, 8'ha5, 8'h5a, 16'h1234}, link_tx_word);
      wr(IDX_OFF_HOOK, 1);
      loop_code <= 5'd20;
      repeat (100) @(posedge clock);
      rdc("loop", IDX_STATUS, 32'h1f, 20);
      wait_frame();
      chk("off-hook", 1, link_tx_word[36]);
      wr(IDX_IRQ_CLEAR, 32'hf);
      rdc("cleared", IDX_EVENTS, 32'hf, 0);
      loop_code <= LOOP_MAX;
      repeat (100) @(posedge clock);
      rdc("loop max", IDX_STATUS, 32'h1f, 32'h1f);
      rdc("overload", IDX_EVENTS, 32'h4, 32'h4);
      wr(IDX_IRQ_CLEAR, 32'h4);
      repeat (60) @(posedge clock);
      rdc("overload once", IDX_EVENTS, 32'h4, 0);
      loop_code <= 5'd0;
      dropout <= 1'b1;
      repeat (100) @(posedge clock);
      rdc("loop drop", IDX_STATUS, 32'h1f, 0);
      rdc("dropout", IDX_EVENTS, 32'h8, 32'h8);
      chk("irq drop", 1, irq);
      ring <= 1'b1;
      repeat (100) @(posedge clock);
      chk("ring", 1, ring_detect);
      chk("rx samples", 1, rxn > 0);
      chk("cid bytes", 1, cidn > 0);
      chk("tx ready", 1, txr > 0);
      wr(IDX_IRQ_ENABLE, 0);
      chk("irq masked", 0, irq);
      wr(IDX_POWER, 32'h10);
      repeat (100) @(posedge clock);
      rdc("fd down", IDX_STATUS, 32'h40, 0);
      chk("tx_enable off", 0, link_tx_enable);
      chk("ring off", 0, ring_detect);
      report_and_stop();
   end
endmodule : daa_link_init_loop_monitor_bench
